//--- src/opmode_pkg.sv
// Constants and carrier types for the operating-mode controller
package opmode_pkg;

    // ==========================================
    // Timing
    localparam int CLK_MHZ = 125; // Clock rate
    localparam int BOOT_WAIT_A_US = 1000; // Boot time, strap low
    localparam int BOOT_WAIT_B_US = 1000; // Boot time, strap high
    localparam int BOOT_PULSE_WIDTH_A_US = 4; // Boot pulse, strap low
    localparam int BOOT_PULSE_WIDTH_B_US = 4; // Boot pulse, strap high
    localparam int MEAS_NS = 800; // One measurement cycle
    localparam int BOOT_WAIT_A_CYC = BOOT_WAIT_A_US * CLK_MHZ;
    localparam int BOOT_WAIT_B_CYC = BOOT_WAIT_B_US * CLK_MHZ;
    localparam int PULSE_A_CYC = BOOT_PULSE_WIDTH_A_US * CLK_MHZ;
    localparam int PULSE_B_CYC = BOOT_PULSE_WIDTH_B_US * CLK_MHZ;
    localparam int MEAS_CYC = (MEAS_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 24; // Counter width

    // ==========================================
    // Encodings and reset values
    localparam logic PIN_B_FUNC_IRQ = 1'h0; // Pin b is interrupt
    localparam logic PIN_B_FUNC_TRIG = 1'h1; // Pin b is trigger input
    localparam logic [7:0] ASLP_OFF = 8'h00; // Auto-sleep disabled

    // Operating modes
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_BOOT = 3'h1,
        MODE_STANDBY = 3'h2,
        MODE_HIBERNATE = 3'h3,
        MODE_WAKE = 3'h4,
        MODE_SLEEP = 3'h5,
        MODE_TRIG_WAIT = 3'h6,
        MODE_TRIG_MEAS = 3'h7
    } mode_t;

    // Host configuration carried as one group
    typedef struct packed {
        logic active; // Active request
        logic hibernate_en; // Hibernate request
        logic pin_b_function_sel; // Pin b function
        logic boot_pulse_to_b; // Route boot pulse to pin b
        logic [7:0] auto_sleep_count; // Auto wake/sleep count
    } host_cfg_t;

    // Status shown to host
    typedef struct packed {
        logic boot_done_flag; // Boot completed
        logic bus_ready; // Serial interface answers
        logic sensor_power; // Sensing blocks powered
        logic motion_defaults; // Motion parameters loaded
        logic auto_wake_sleep; // Auto switching enabled
    } status_t;

endpackage : opmode_pkg

//--- src/accel_operating_mode_control.sv
// Operating-mode sequencer: boot, hibernate, standby, active modes
`timescale 1ns/1ns
module accel_operating_mode_control #(
    parameter int BOOT_A_CYC = opmode_pkg::BOOT_WAIT_A_CYC, // Boot time strap low
    parameter int BOOT_B_CYC = opmode_pkg::BOOT_WAIT_B_CYC // Boot time strap high
) (
    input wire logic clk, // Clock 125 MHz
    input wire logic rst, // Sync reset, high
    input wire logic ce, // Clock enable
    input wire logic supply_ok, // Supply above minimum
    input wire logic boot_strap_select, // Boot strap level
    input wire logic wake_pin, // Chip-select / wake pin
    input wire logic motion_detect_pin, // Motion-detect pin level
    input wire logic irq_b_in, // Pin b input level (trigger)
    input wire opmode_pkg::host_cfg_t cfg, // Host configuration
    input wire logic activity, // Activity detected
    input wire logic inactivity_done, // Inactivity timeout
    input wire logic clear_boot_flag, // Host clears boot flag
    output opmode_pkg::mode_t mode, // Current mode
    output opmode_pkg::status_t status, // Status bits
    output logic irq_out_a, // Interrupt pin a
    output logic irq_out_b, // Interrupt pin b
    output logic regs_to_default, // Pulse: reload register defaults
    output logic otp_load // Level: loading defaults
);

    // ==========================================
    // State
    opmode_pkg::mode_t next_mode; // Next mode
    logic [opmode_pkg::CNT_W-1:0] boot_cnt; // Boot timer
    logic [opmode_pkg::CNT_W-1:0] pulse_cnt; // Boot pulse timer
    logic [opmode_pkg::CNT_W-1:0] meas_cnt; // Measurement timer
    logic strap; // Strap caught at boot start
    logic wake_prev; // Last wake pin level
    logic trig_prev; // Last pin b level
    logic boot_flag; // Boot done flag
    logic pulse_pin_b; // Pulse goes to pin b
    logic aws_en; // Auto wake/sleep allowed
    logic boot_end; // Boot timer expiry
    logic trig_rise; // Trigger rising edge
    logic meas_end; // Measurement done

    assign boot_end = (mode == opmode_pkg::MODE_BOOT) && (boot_cnt == '0);
    assign trig_rise = irq_b_in && !trig_prev;
    assign meas_end = (meas_cnt == '0);

    // ==========================================
    // Next-mode decision
    always_comb begin
        next_mode = mode;
        unique case (mode)
            opmode_pkg::MODE_OFF: begin
                if (supply_ok) next_mode = opmode_pkg::MODE_BOOT;
            end
            opmode_pkg::MODE_BOOT: begin
                if (boot_end) begin
                    // Strap high lands in wake automatically
                    next_mode = strap ? opmode_pkg::MODE_WAKE
                                      : opmode_pkg::MODE_STANDBY;
                end
            end
            opmode_pkg::MODE_STANDBY: begin
                if (!strap && cfg.hibernate_en) begin
                    next_mode = opmode_pkg::MODE_HIBERNATE;
                end else if (strap && !motion_detect_pin) begin
                    next_mode = opmode_pkg::MODE_HIBERNATE;
                end else if (!strap && cfg.pin_b_function_sel) begin
                    next_mode = opmode_pkg::MODE_TRIG_WAIT;
                end else if (cfg.active) begin
                    next_mode = opmode_pkg::MODE_WAKE;
                end
            end
            opmode_pkg::MODE_HIBERNATE: begin
                if (!strap && (wake_pin != wake_prev)) begin
                    next_mode = opmode_pkg::MODE_BOOT;
                end else if (strap && motion_detect_pin) begin
                    next_mode = opmode_pkg::MODE_BOOT;
                end
            end
            opmode_pkg::MODE_WAKE: begin
                if (!cfg.active) begin
                    next_mode = opmode_pkg::MODE_STANDBY;
                end else if (aws_en && inactivity_done) begin
                    next_mode = opmode_pkg::MODE_SLEEP;
                end
            end
            opmode_pkg::MODE_SLEEP: begin
                if (!cfg.active) begin
                    next_mode = opmode_pkg::MODE_STANDBY;
                end else if (!aws_en || activity) begin
                    next_mode = opmode_pkg::MODE_WAKE;
                end
            end
            opmode_pkg::MODE_TRIG_WAIT: begin
                if (strap || !cfg.pin_b_function_sel) begin
                    next_mode = opmode_pkg::MODE_STANDBY;
                end else if (trig_rise) begin
                    next_mode = opmode_pkg::MODE_TRIG_MEAS;
                end
            end
            opmode_pkg::MODE_TRIG_MEAS: begin
                if (meas_end) next_mode = opmode_pkg::MODE_TRIG_WAIT;
            end
        endcase
        if (!supply_ok) next_mode = opmode_pkg::MODE_OFF;
    end

    // ==========================================
    // Mode register
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= opmode_pkg::MODE_OFF;
        end else if (ce) begin
            mode <= next_mode;
        end
    end

    // ==========================================
    // Strap capture at each boot entry
    always_ff @(posedge clk) begin
        if (rst) begin
            strap <= 1'h0;
        end else if (ce && next_mode == opmode_pkg::MODE_BOOT && mode != opmode_pkg::MODE_BOOT) begin
            strap <= boot_strap_select;
        end
    end

    // ==========================================
    // Boot timer
    always_ff @(posedge clk) begin
        if (rst) begin
            boot_cnt <= '0;
        end else if (ce) begin
            if (next_mode == opmode_pkg::MODE_BOOT && mode != opmode_pkg::MODE_BOOT) begin
                // Load length for the strap being latched
                boot_cnt <= boot_strap_select ? opmode_pkg::CNT_W'(BOOT_B_CYC - 1)
                                              : opmode_pkg::CNT_W'(BOOT_A_CYC - 1);
            end else if (mode == opmode_pkg::MODE_BOOT && boot_cnt != '0) begin
                boot_cnt <= boot_cnt - 1'b1;
            end
        end
    end

    // ==========================================
    // Boot pulse timer
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_cnt <= '0;
        end else if (ce) begin
            if (mode != opmode_pkg::MODE_BOOT && next_mode == opmode_pkg::MODE_OFF) begin
                pulse_cnt <= '0;
            end else if (boot_end) begin
                pulse_cnt <= strap ? opmode_pkg::CNT_W'(opmode_pkg::PULSE_B_CYC)
                                   : opmode_pkg::CNT_W'(opmode_pkg::PULSE_A_CYC);
            end else if (pulse_cnt != '0) begin
                pulse_cnt <= pulse_cnt - 1'b1;
            end
        end
    end

    // ==========================================
    // Pulse routing; strap high forces pin b
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_pin_b <= 1'h0;
        end else if (ce) begin
            if (boot_end) begin
                pulse_pin_b <= strap | cfg.boot_pulse_to_b;
            end
        end
    end

    // ==========================================
    // Boot done flag; set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            boot_flag <= 1'h0;
        end else if (ce) begin
            if (boot_end) begin
                boot_flag <= 1'h1;
            end else if (mode == opmode_pkg::MODE_HIBERNATE || mode == opmode_pkg::MODE_OFF) begin
                boot_flag <= 1'h0;
            end else if (clear_boot_flag) begin
                boot_flag <= 1'h0;
            end
        end
    end

    // ==========================================
    // Auto wake/sleep enable; off during boot, then on for a nonzero auto_sleep_count
    always_ff @(posedge clk) begin
        if (rst) begin
            aws_en <= 1'h0;
        end else if (ce) begin
            if (mode == opmode_pkg::MODE_BOOT) begin
                aws_en <= 1'h0;
            end else begin
                aws_en <= (cfg.auto_sleep_count != opmode_pkg::ASLP_OFF);
            end
        end
    end

    // ==========================================
    // Edge history for wake and trigger pins
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_prev <= 1'h1; // Select pin idles high
            trig_prev <= 1'h0;
        end else if (ce) begin
            wake_prev <= wake_pin;
            trig_prev <= irq_b_in;
        end
    end

    // ==========================================
    // Measurement timer for triggered cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            meas_cnt <= '0;
        end else if (ce) begin
            if (mode == opmode_pkg::MODE_TRIG_WAIT && next_mode == opmode_pkg::MODE_TRIG_MEAS) begin
                meas_cnt <= opmode_pkg::CNT_W'(opmode_pkg::MEAS_CYC - 1);
            end else if (meas_cnt != '0) begin
                meas_cnt <= meas_cnt - 1'b1;
            end
        end
    end

    // ==========================================
    // Registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
            irq_out_a <= 1'h0;
            irq_out_b <= 1'h0;
            regs_to_default <= 1'h0;
            otp_load <= 1'h0;
        end else if (ce) begin
            status.boot_done_flag <= boot_flag;
            // Bus silent in off, boot and hibernate
            status.bus_ready <= (next_mode != opmode_pkg::MODE_OFF)
                && (next_mode != opmode_pkg::MODE_BOOT)
                && (next_mode != opmode_pkg::MODE_HIBERNATE);
            // Sensing in wake, sleep and triggered measurement
            status.sensor_power <= (next_mode == opmode_pkg::MODE_WAKE)
                || (next_mode == opmode_pkg::MODE_SLEEP)
                || (next_mode == opmode_pkg::MODE_TRIG_MEAS);
            status.motion_defaults <= (mode == opmode_pkg::MODE_BOOT)
                ? strap : status.motion_defaults;
            status.auto_wake_sleep <= aws_en;
            irq_out_a <= (pulse_cnt != '0) && !pulse_pin_b;
            irq_out_b <= (pulse_cnt != '0) && pulse_pin_b;
            // Defaults reloaded on each boot entry
            regs_to_default <= (next_mode == opmode_pkg::MODE_BOOT)
                && (mode != opmode_pkg::MODE_BOOT);
            otp_load <= (next_mode == opmode_pkg::MODE_BOOT);
        end
    end

    // ==========================================
    // Checks
    // Strap low boot lands in standby
    chk_boot_to_standby: assert property (@(posedge clk) disable iff (rst)
        ce && boot_end && !strap |=> mode == opmode_pkg::MODE_STANDBY || !supply_ok)
        else $error("boot did not reach standby");

    // Strap high boot lands in wake
    chk_boot_to_wake: assert property (@(posedge clk) disable iff (rst)
        ce && boot_end && strap && supply_ok |=> mode == opmode_pkg::MODE_WAKE)
        else $error("strap high boot did not reach wake");

    // Flag visible two edges after boot end
    chk_flag_set: assert property (@(posedge clk) disable iff (rst)
        ce && boot_end |=> ##1 !ce || status.boot_done_flag)
        else $error("boot flag not set");

    // Strap high keeps pin a quiet
    chk_pulse_route: assert property (@(posedge clk) disable iff (rst)
        strap && mode != opmode_pkg::MODE_BOOT |-> !irq_out_a)
        else $error("pulse on pin a with strap high");

    // Bus shut while booting
    chk_bus_quiet: assert property (@(posedge clk) disable iff (rst)
        mode == opmode_pkg::MODE_BOOT && $past(mode) == opmode_pkg::MODE_BOOT |-> !status.bus_ready)
        else $error("bus open during boot");

    // Any wake pin change leaves hibernate with strap low
    chk_wake_toggle: assert property (@(posedge clk) disable iff (rst)
        ce && supply_ok && mode == opmode_pkg::MODE_HIBERNATE && !strap && wake_pin != wake_prev
        |=> mode == opmode_pkg::MODE_BOOT)
        else $error("wake toggle ignored");

    // Low motion pin holds hibernate
    chk_motion_hold: assert property (@(posedge clk) disable iff (rst)
        ce && mode == opmode_pkg::MODE_HIBERNATE && strap && !motion_detect_pin
        |=> mode inside {opmode_pkg::MODE_HIBERNATE, opmode_pkg::MODE_OFF})
        else $error("left hibernate with motion pin low");

    // Trigger edge starts measurement
    chk_trig_start: assert property (@(posedge clk) disable iff (rst)
        ce && supply_ok && mode == opmode_pkg::MODE_TRIG_WAIT && !strap
        && cfg.pin_b_function_sel && trig_rise |=> mode == opmode_pkg::MODE_TRIG_MEAS)
        else $error("trigger edge ignored");

    // Measurement end returns to wait
    chk_trig_return: assert property (@(posedge clk) disable iff (rst)
        ce && supply_ok && mode == opmode_pkg::MODE_TRIG_MEAS && meas_end
        |=> mode == opmode_pkg::MODE_TRIG_WAIT)
        else $error("no return to trigger wait");

    // Hibernate keeps bus and sensing off
    chk_hib_quiet: assert property (@(posedge clk) disable iff (rst)
        mode == opmode_pkg::MODE_HIBERNATE |-> !status.bus_ready && !status.sensor_power)
        else $error("bus or sensing on in hibernate");

    // Standby answers the bus with sensing off
    chk_standby_bus: assert property (@(posedge clk) disable iff (rst)
        mode == opmode_pkg::MODE_STANDBY |-> status.bus_ready && !status.sensor_power)
        else $error("standby bus or sensing wrong");

    // In trigger mode, sensing powered only while measuring
    chk_trig_power: assert property (@(posedge clk) disable iff (rst)
        mode inside {opmode_pkg::MODE_TRIG_WAIT, opmode_pkg::MODE_TRIG_MEAS}
        |-> status.sensor_power == (mode == opmode_pkg::MODE_TRIG_MEAS))
        else $error("sensing power wrong in trigger mode");

    // Every boot entry reloads register defaults
    chk_reload_boot: assert property (@(posedge clk) disable iff (rst)
        ce && next_mode == opmode_pkg::MODE_BOOT && mode != opmode_pkg::MODE_BOOT
        |=> regs_to_default)
        else $error("no default reload on boot entry");

    // Auto switching held off while booting
    chk_auto_boot_off: assert property (@(posedge clk) disable iff (rst)
        ce && mode == opmode_pkg::MODE_BOOT |=> !aws_en)
        else $error("auto switching on during boot");

    // Motion defaults follow the latched strap
    chk_motion_strap: assert property (@(posedge clk) disable iff (rst)
        mode inside {opmode_pkg::MODE_STANDBY, opmode_pkg::MODE_WAKE, opmode_pkg::MODE_SLEEP}
        |-> status.motion_defaults == strap)
        else $error("motion defaults do not match strap");

    // ==========================================
    // Cover points
    cov_boot_done: cover property (@(posedge clk) disable iff (rst) boot_end);
    cov_hib_wake: cover property (@(posedge clk) disable iff (rst)
        mode == opmode_pkg::MODE_HIBERNATE ##1 mode == opmode_pkg::MODE_BOOT);
    cov_trig: cover property (@(posedge clk) disable iff (rst)
        mode == opmode_pkg::MODE_TRIG_MEAS ##1 mode == opmode_pkg::MODE_TRIG_WAIT);
    cov_sleep: cover property (@(posedge clk) disable iff (rst) mode == opmode_pkg::MODE_SLEEP);
    cov_strap_wake: cover property (@(posedge clk) disable iff (rst) boot_end && strap);

endmodule : accel_operating_mode_control

//--- bench/host_mcu_model.sv
// Host microcontroller model driving the wake, motion and trigger pins
`timescale 1ns/1ns
module host_mcu_model (
    input wire logic clk, // Clock
    input wire logic bus_ready, // Device answers serial traffic
    output logic wake_pin, // Chip-select / wake pin
    output logic motion_detect_pin, // Motion-detect level
    output logic irq_b_in // Trigger drive on pin b
);
    // ==========================================
    // Idle levels: select idle high, motion line pulled up
    initial begin
        wake_pin = 1'h1;
        motion_detect_pin = 1'h1;
        irq_b_in = 1'h0;
    end

    // Flip the wake pin; either direction counts
    task automatic toggle_wake();
        @(negedge clk);
        wake_pin = ~wake_pin;
    endtask : toggle_wake

    // Set the motion-detect level
    task automatic set_motion(input logic v);
        @(negedge clk);
        motion_detect_pin = v;
    endtask : set_motion

    // One low-to-high edge, held a few cycles
    task automatic trigger_edge();
        @(negedge clk);
        irq_b_in = 1'h1;
        repeat (3) @(negedge clk);
        irq_b_in = 1'h0;
    endtask : trigger_edge

    // No serial traffic until the device has finished booting
    task automatic wait_bus(input int lim, output logic ok);
        int n;
        n = 0;
        while (bus_ready !== 1'h1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        ok = bus_ready;
    endtask : wait_bus
endmodule : host_mcu_model

//--- bench/accel_operating_mode_control_tb.sv
// Self-checking testbench for the operating-mode sequencer
`timescale 1ns/1ns
module accel_operating_mode_control_tb;
    // ==========================================
    // Short boot counts keep the run brief
    localparam int BOOT_A = 20; // Boot cycles, strap low
    localparam int BOOT_B = 30; // Boot cycles, strap high
    localparam int LIMIT = 20000; // Hang ceiling in cycles
    logic clk, rst, supply_ok, boot_strap_select, activity, inactivity_done, clear_boot_flag, ok;
    logic irq_out_a, irq_out_b, regs_to_default, otp_load, wake_pin, motion_detect_pin, irq_b_in;
    logic ce; // Clock enable drive
    opmode_pkg::host_cfg_t cfg; // Host configuration
    opmode_pkg::mode_t mode; // Observed mode
    opmode_pkg::status_t status; // Observed status
    int mismatches, total_checks, cycles, n, pulse_a, pulse_b, defaults_seen;

    accel_operating_mode_control #(.BOOT_A_CYC(BOOT_A), .BOOT_B_CYC(BOOT_B))
        accel_operating_mode_control_inst (.clk(clk), .rst(rst), .ce(ce),
        .supply_ok(supply_ok), .boot_strap_select(boot_strap_select), .wake_pin(wake_pin),
        .motion_detect_pin(motion_detect_pin), .irq_b_in(irq_b_in), .cfg(cfg),
        .activity(activity), .inactivity_done(inactivity_done),
        .clear_boot_flag(clear_boot_flag), .mode(mode), .status(status),
        .irq_out_a(irq_out_a), .irq_out_b(irq_out_b), .regs_to_default(regs_to_default),
        .otp_load(otp_load));
    host_mcu_model host_mcu_model_inst (.clk(clk), .bus_ready(status.bus_ready),
        .wake_pin(wake_pin), .motion_detect_pin(motion_detect_pin), .irq_b_in(irq_b_in));

    // ==========================================
    // Clock, 8 ns period
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // Pulse and reload counters, plus hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq_out_a === 1'h1) pulse_a <= pulse_a + 1;
        if (irq_out_b === 1'h1) pulse_b <= pulse_b + 1;
        if (regs_to_default === 1'h1) defaults_seen <= defaults_seen + 1;
        if (cycles >= LIMIT) begin
            mismatches++;
            $display("Error timeout expected 0 seen %0d", cycles);
            final_report();
        end
    end

    // ==========================================
    // Compare tasks
    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_bit

    task automatic check_mode(input opmode_pkg::mode_t exp);
        total_checks++;
        if (mode !== exp) begin
            mismatches++;
            $display("Error mode expected %h seen %h", exp, mode);
        end
    endtask : check_mode

    // Wait for a mode under a bound, then compare
    task automatic wait_mode(input opmode_pkg::mode_t m, input int lim, output int k);
        k = 0;
        while (mode !== m && k < lim) begin
            @(negedge clk);
            k++;
        end
        check_mode(m);
    endtask : wait_mode

    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask : step

    task automatic clear_counts();
        pulse_a = 0;
        pulse_b = 0;
        defaults_seen = 0;
    endtask : clear_counts

    // After a boot: flag, one reload, pulse on the chosen pin only
    task automatic check_boot(input logic on_a, input logic motion);
        int pw;
        pw = on_a ? opmode_pkg::PULSE_A_CYC : opmode_pkg::PULSE_B_CYC;
        step(pw + 10);
        check_bit("boot flag", 1'h1, status.boot_done_flag);
        check_bit("pulse width", 1'h1, (on_a ? pulse_a : pulse_b) == pw);
        check_bit("otp done", 1'h0, otp_load);
        check_bit("other pin quiet", 1'h1, (on_a ? pulse_b : pulse_a) == 0);
        check_bit("defaults reload", 1'h1, defaults_seen == 1);
        check_bit("motion defaults", motion, status.motion_defaults);
    endtask : check_boot

    task automatic final_report();
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // ==========================================
    // Main sequence
    initial begin
        rst = 1'h1;
        ce = 1'h1;
        supply_ok = 1'h0;
        boot_strap_select = 1'h0;
        activity = 1'h0;
        inactivity_done = 1'h0;
        clear_boot_flag = 1'h0;
        cfg = '0;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        clear_counts();
        step(20);
        rst = 1'h0;
        step(2);
        // Power-up boot with strap low
        check_mode(opmode_pkg::MODE_OFF);
        check_bit("bus off", 1'h0, status.bus_ready);
        supply_ok = 1'h1;
        wait_mode(opmode_pkg::MODE_BOOT, 4, n);
        check_bit("otp load", 1'h1, otp_load);
        check_bit("bus in boot", 1'h0, status.bus_ready);
        wait_mode(opmode_pkg::MODE_STANDBY, BOOT_A + 5, n);
        check_bit("boot length", 1'h1, n >= BOOT_A - 3);
        host_mcu_model_inst.wait_bus(4, ok);
        check_bit("bus standby", 1'h1, ok);
        check_bit("sensor off", 1'h0, status.sensor_power);
        check_boot(1'h1, 1'h0);
        clear_boot_flag = 1'h1;
        step(1);
        clear_boot_flag = 1'h0;
        step(2);
        check_bit("flag cleared", 1'h0, status.boot_done_flag);
        // Two triggered measurements back to back
        cfg.pin_b_function_sel = opmode_pkg::PIN_B_FUNC_TRIG;
        wait_mode(opmode_pkg::MODE_TRIG_WAIT, 4, n);
        repeat (2) begin
            host_mcu_model_inst.trigger_edge();
            wait_mode(opmode_pkg::MODE_TRIG_MEAS, 4, n);
            check_bit("bus in trigger", 1'h1, status.bus_ready);
            check_bit("sensor measuring", 1'h1, status.sensor_power);
            wait_mode(opmode_pkg::MODE_TRIG_WAIT, opmode_pkg::MEAS_CYC + 5, n);
            check_bit("meas length", 1'h1, n >= opmode_pkg::MEAS_CYC - 10);
            check_bit("sensor idle", 1'h0, status.sensor_power);
        end
        cfg.pin_b_function_sel = opmode_pkg::PIN_B_FUNC_IRQ;
        wait_mode(opmode_pkg::MODE_STANDBY, 4, n);
        // Active with auto wake/sleep; clock enable low first holds standby
        ce = 1'h0;
        cfg.active = 1'h1;
        step(5);
        check_mode(opmode_pkg::MODE_STANDBY);
        ce = 1'h1;
        wait_mode(opmode_pkg::MODE_WAKE, 4, n);
        check_bit("bus active", 1'h1, status.bus_ready);
        check_bit("sensor wake", 1'h1, status.sensor_power);
        inactivity_done = 1'h1;
        step(5);
        check_mode(opmode_pkg::MODE_WAKE);
        cfg.auto_sleep_count = 8'h01;
        wait_mode(opmode_pkg::MODE_SLEEP, 4, n);
        check_bit("auto on", 1'h1, status.auto_wake_sleep);
        inactivity_done = 1'h0;
        activity = 1'h1;
        wait_mode(opmode_pkg::MODE_WAKE, 4, n);
        activity = 1'h0;
        cfg.active = 1'h0;
        cfg.auto_sleep_count = 8'h00;
        wait_mode(opmode_pkg::MODE_STANDBY, 4, n);
        check_bit("regs kept", 1'h1, defaults_seen == 1);
        // Hibernate and wake by pin toggle, pulse moved to pin b
        cfg.hibernate_en = 1'h1;
        wait_mode(opmode_pkg::MODE_HIBERNATE, 4, n);
        cfg.hibernate_en = 1'h0;
        cfg.boot_pulse_to_b = 1'h1;
        check_bit("bus hibernate", 1'h0, status.bus_ready);
        check_bit("sensor hibernate", 1'h0, status.sensor_power);
        step(20);
        check_mode(opmode_pkg::MODE_HIBERNATE);
        clear_counts();
        host_mcu_model_inst.toggle_wake();
        wait_mode(opmode_pkg::MODE_BOOT, 4, n);
        wait_mode(opmode_pkg::MODE_STANDBY, BOOT_A + 5, n);
        check_boot(1'h0, 1'h0);
        // Strap high power-up
        supply_ok = 1'h0;
        wait_mode(opmode_pkg::MODE_OFF, 4, n);
        boot_strap_select = 1'h1;
        cfg.boot_pulse_to_b = 1'h0;
        cfg.active = 1'h1;
        cfg.pin_b_function_sel = opmode_pkg::PIN_B_FUNC_IRQ;
        clear_counts();
        supply_ok = 1'h1;
        wait_mode(opmode_pkg::MODE_BOOT, 4, n);
        check_bit("bus strap boot", 1'h0, status.bus_ready);
        wait_mode(opmode_pkg::MODE_WAKE, BOOT_B + 5, n);
        check_bit("strap boot length", 1'h1, n >= BOOT_B - 3);
        check_bit("bus after detect", 1'h1, status.bus_ready);
        check_boot(1'h0, 1'h1);
        check_bit("auto default off", 1'h0, status.auto_wake_sleep);
        host_mcu_model_inst.trigger_edge();
        step(3);
        check_mode(opmode_pkg::MODE_WAKE);
        cfg.auto_sleep_count = 8'h01;
        step(3);
        check_bit("auto enabled", 1'h1, status.auto_wake_sleep);
        cfg.auto_sleep_count = 8'h00;
        cfg.active = 1'h0;
        wait_mode(opmode_pkg::MODE_STANDBY, 4, n);
        // Motion pin low holds hibernate, high level boots
        host_mcu_model_inst.set_motion(1'h0);
        wait_mode(opmode_pkg::MODE_HIBERNATE, 4, n);
        step(30);
        check_mode(opmode_pkg::MODE_HIBERNATE);
        host_mcu_model_inst.set_motion(1'h1);
        wait_mode(opmode_pkg::MODE_BOOT, 4, n);
        final_report();
    end
endmodule : accel_operating_mode_control_tb
